// [shared/sp_defines.vh]
// Function
// [R1] address hold: stretch, interrupt after address byte
// [R2] address match clears clock release, sets flag
// [R3] start sets status; flag if enabled
// [R4] expose ack phase, read/write, data/address
// [R5] reading data buffer clears buffer full
// [R6] firmware ack value answers the address
// [R7] setting clock release ends the stretch
// [R8] after read ack: clear release, set flag
// [R9] buffer loaded after ack; load sets full
// [R10] master ack on ninth pulse captured
// [R11] repeat per byte; nack releases bus
// [R12] master nacks final byte read
// [R13] rate values 0..2 unsupported in master
// [R14] mode field offers spi clock rates
// [R15] interrupt flag sticky until firmware clears
`ifndef SP_DEFINES_VH
`define SP_DEFINES_VH
// ****************
// register byte addresses
// ****************
`define SP_CTRL1_ADDR 12'h000
`define SP_CTRL2_ADDR 12'h004
`define SP_CTRL3_ADDR 12'h008
`define SP_STAT_ADDR 12'h00C
`define SP_BUF_ADDR 12'h010
`define SP_RATE_ADDR 12'h014
`define SP_IRQ_STAT_ADDR 12'h018
`define SP_IRQ_EN_ADDR 12'h01C
`define SP_IRQ_CLR_ADDR 12'h020
// ****************
// fields and reset values
// ****************
`define SP_CTRL1_RST 8'h00
`define SP_C1_EN 5
`define SP_C1_CKP 4
`define SP_C2_RECEIVED_ACK_VALUE 6
`define SP_C2_ACK_VALUE_TO_SEND 5
`define SP_C3_ACK_PHASE_FLAG 7
`define SP_C3_PCIE 6
`define SP_C3_SCIE 5
`define SP_C3_ADDRESS_HOLD_ENABLE 1
`define SP_ST_DA 5
`define SP_ST_S 3
`define SP_ST_RW 2
`define SP_ST_BF 0
`define SP_MODE_I2C_S7 4'h6
`define SP_MODE_I2C_S7I 4'hE
`define SP_MODE_SPI_M4 4'h0
`define SP_MODE_SPI_M16 4'h1
`define SP_MODE_SPI_M64 4'h2
`define SP_MODE_SPI_T2 4'h3
`define SP_EV_START 0
`define SP_EV_ADDR 1
`define SP_EV_DATA 2
`define SP_EV_STOP 3
`endif

// [design/pin_sync.v]
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  // pin
  input wire pin_i,
  output reg sync_o
);
  reg stage;
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage <= 1'b1;
      sync_o <= 1'b1;
    end else if (clk_en_i) begin
      stage <= pin_i;
      sync_o <= stage;
    end
  end
endmodule

// [design/spi_clk_div.v]
`timescale 1ns/1ps
`include "sp_defines.vh"
module spi_clk_div (
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  // selection
  input wire [3:0] mode_i,
  input wire timer_two_i,
  output reg spi_sck_o
);
  reg [4:0] cnt;
  reg t2_q;
  reg [4:0] half;
  wire t2_rise;
  assign t2_rise = timer_two_i & ~t2_q;
  always @* begin
    case (mode_i)
      `SP_MODE_SPI_M4: half = 5'h01; // [R14]
      `SP_MODE_SPI_M16: half = 5'h07; // [R14]
      `SP_MODE_SPI_M64: half = 5'h1F; // [R14]
      default: half = 5'h00;
    endcase
  end
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 5'h00;
      t2_q <= 1'b0;
      spi_sck_o <= 1'b0;
    end else if (clk_en_i) begin
      t2_q <= timer_two_i;
      if (mode_i == `SP_MODE_SPI_T2) begin
        cnt <= 5'h00;
        if (t2_rise)
          spi_sck_o <= ~spi_sck_o; // [R14]
      end else if (mode_i > `SP_MODE_SPI_T2) begin
        cnt <= 5'h00;
        spi_sck_o <= 1'b0;
      end else if (cnt >= half) begin
        cnt <= 5'h00;
        spi_sck_o <= ~spi_sck_o;
      end else begin
        cnt <= cnt + 5'h01;
      end
    end
  end
endmodule

// [design/serial_port_i2c_slave_tx_hold.v]
`timescale 1ns/1ps
`include "sp_defines.vh"
module serial_port_i2c_slave_tx_hold #(
  parameter [6:0] OWN_ADDR = 7'h2A
) (
  // clock, reset, enable
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // i2c pins
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // spi clock and timer
  input wire timer_two_i,
  output wire spi_sck_o,
  // interrupt
  output wire irq_o
);
  // ****************
  // states
  // ****************
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_TX = 3'd3;
  localparam ST_MACK = 3'd4;
  localparam ST_RX = 3'd5;
  localparam ST_SACK = 3'd6;

  reg [7:0] ctrl1;
  reg ack_value_to_send, received_ack_value, ack_phase_flag, pcie, scie, address_hold_enable;
  reg da, s_bit, rw, bf;
  reg [7:0] buffer;
  reg [7:0] rate;
  reg [3:0] irq_stat;
  reg [3:0] irq_en;
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg scl_q, sda_q;
  reg sda_drive;
  reg [3:0] ev;
  wire scl_s, sda_s;
  wire wr, rd;
  wire scl_rise, scl_fall, start_det, stop_det;
  wire i2c_on;

  pin_sync u_scl (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .pin_i(scl_i),
    .sync_o(scl_s)
  );
  pin_sync u_sda (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .pin_i(sda_i),
    .sync_o(sda_s)
  );
  spi_clk_div u_div (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .mode_i(ctrl1[3:0]),
    .timer_two_i(timer_two_i),
    .spi_sck_o(spi_sck_o)
  );

  // ****************
  // bus decode
  // ****************
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel & penable & pwrite & clk_en_i;
  assign rd = psel & penable & ~pwrite & clk_en_i;
  assign i2c_on = ctrl1[`SP_C1_EN] &
    ((ctrl1[3:0] == `SP_MODE_I2C_S7) | (ctrl1[3:0] == `SP_MODE_I2C_S7I));
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // clock held low while release bit is clear and a transfer is open
  assign scl_o = 1'b0;
  assign scl_oe_o = i2c_on & ~ctrl1[`SP_C1_CKP] & (state != ST_IDLE);
  assign sda_o = 1'b0;
  assign sda_oe_o = i2c_on & sda_drive;
  assign irq_o = |(irq_stat & irq_en);

  always @* begin
    case (paddr)
      `SP_CTRL1_ADDR: prdata = {24'h000000, ctrl1};
      `SP_CTRL2_ADDR: prdata = {25'h0000000, received_ack_value, ack_value_to_send, 5'h00};
      `SP_CTRL3_ADDR: prdata = {24'h000000, ack_phase_flag, pcie, scie, 3'h0,
        address_hold_enable, 1'b0}; // [R4]
      `SP_STAT_ADDR: prdata = {26'h0000000, da, 1'b0, s_bit, rw, 1'b0,
        bf}; // [R4]
      `SP_BUF_ADDR: prdata = {24'h000000, buffer};
      `SP_RATE_ADDR: prdata = {24'h000000, rate};
      `SP_IRQ_STAT_ADDR: prdata = {28'h0000000, irq_stat};
      `SP_IRQ_EN_ADDR: prdata = {28'h0000000, irq_en};
      default: prdata = 32'h00000000;
    endcase
  end

  // ****************
  // protocol engine and registers
  // ****************
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl1 <= `SP_CTRL1_RST;
      ack_value_to_send <= 1'b0;
      received_ack_value <= 1'b0;
      ack_phase_flag <= 1'b0;
      pcie <= 1'b0;
      scie <= 1'b0;
      address_hold_enable <= 1'b0;
      da <= 1'b0;
      s_bit <= 1'b0;
      rw <= 1'b0;
      bf <= 1'b0;
      buffer <= 8'h00;
      rate <= 8'h00;
      irq_stat <= 4'h0;
      irq_en <= 4'h0;
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_drive <= 1'b0;
      ev <= 4'h0;
    end else if (clk_en_i) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      // events land in irq status one cycle later
      ev <= 4'h0;
      // firmware side
      if (wr) begin
        case (paddr)
          `SP_CTRL1_ADDR: ctrl1 <= pwdata[7:0]; // [R7]
          `SP_CTRL2_ADDR: ack_value_to_send <= pwdata[`SP_C2_ACK_VALUE_TO_SEND]; // [R6]
          `SP_CTRL3_ADDR: begin
            pcie <= pwdata[`SP_C3_PCIE];
            scie <= pwdata[`SP_C3_SCIE];
            address_hold_enable <= pwdata[`SP_C3_ADDRESS_HOLD_ENABLE];
          end
          `SP_BUF_ADDR: begin
            buffer <= pwdata[7:0];
            shreg <= pwdata[7:0];
            bf <= 1'b1; // [R9]
          end
          `SP_RATE_ADDR: rate <= pwdata[7:0]; // [R13]
          `SP_IRQ_EN_ADDR: irq_en <= pwdata[3:0];
          default: ;
        endcase
      end
      if (rd && paddr == `SP_BUF_ADDR)
        bf <= 1'b0; // [R5]
      // bus side
      if (!i2c_on || stop_det) begin
        if (stop_det && pcie)
          ev[`SP_EV_STOP] <= 1'b1;
        state <= ST_IDLE;
        sda_drive <= 1'b0;
        ack_phase_flag <= 1'b0;
        s_bit <= 1'b0;
      end else if (start_det) begin
        s_bit <= 1'b1; // [R3]
        if (scie)
          ev[`SP_EV_START] <= 1'b1; // [R3]
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_drive <= 1'b0;
        ack_phase_flag <= 1'b0;
      end else begin
        case (state)
          ST_ADDR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              if (shreg[7:1] == OWN_ADDR) begin
                buffer <= shreg;
                bf <= 1'b1;
                rw <= shreg[0]; // [R4]
                da <= 1'b0;
                ack_phase_flag <= 1'b1;
                state <= ST_AACK;
                if (address_hold_enable) begin
                  ctrl1[`SP_C1_CKP] <= 1'b0; // [R1] [R2]
                  ev[`SP_EV_ADDR] <= 1'b1; // [R1] [R2]
                end else begin
                  sda_drive <= ~ack_value_to_send;
                end
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            // ack level set under the stretch, so it is stable
            // before the clock is released
            sda_drive <= ~ack_value_to_send; // [R6]
            if (scl_fall && ctrl1[`SP_C1_CKP]) begin
              ack_phase_flag <= 1'b0;
              bitcnt <= 4'h0;
              if (ack_value_to_send) begin
                sda_drive <= 1'b0;
                state <= ST_IDLE;
              end else if (rw) begin
                ctrl1[`SP_C1_CKP] <= 1'b0; // [R8]
                ev[`SP_EV_DATA] <= 1'b1; // [R8]
                da <= 1'b1;
                sda_drive <= 1'b0;
                state <= ST_TX;
              end else begin
                sda_drive <= 1'b0;
                da <= 1'b1;
                state <= ST_RX;
              end
            end
          end
          ST_TX: begin
            // first bit goes out under the stretch, before release
            if (bitcnt == 4'h0) begin
              if (bf)
                sda_drive <= ~shreg[7]; // [R9] [R11]
              if (bf && ctrl1[`SP_C1_CKP])
                bitcnt <= 4'h1;
            end else if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_drive <= 1'b0;
                bf <= 1'b0;
                state <= ST_MACK;
              end else begin
                sda_drive <= ~shreg[6];
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise)
              received_ack_value <= sda_s; // [R10]
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (received_ack_value) begin
                state <= ST_IDLE; // [R11] [R12]
              end else begin
                ctrl1[`SP_C1_CKP] <= 1'b0; // [R11]
                ev[`SP_EV_DATA] <= 1'b1; // [R11]
                state <= ST_TX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              buffer <= shreg;
              bf <= 1'b1;
              sda_drive <= ~ack_value_to_send;
              ev[`SP_EV_DATA] <= 1'b1;
              state <= ST_SACK;
            end
          end
          ST_SACK: begin
            if (scl_fall) begin
              sda_drive <= 1'b0;
              bitcnt <= 4'h0;
              state <= ST_RX;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
      // hardware set wins over firmware clear
      irq_stat <= (wr && paddr == `SP_IRQ_CLR_ADDR ?
        irq_stat & ~pwdata[3:0] : irq_stat) | ev; // [R15]
    end
  end
endmodule

// [verification/sp_checker_sva.sv]
`timescale 1ns/1ps
module sp_checker (
  // clock, reset, enable
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // i2c and interrupt
  input wire scl_i,
  input wire scl_oe_o,
  input wire sda_oe_o,
  input wire irq_o
);
  wire acc = psel && penable && clk_en_i;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  chk_apb_zero_wait: assert property (acc |-> pready && !pslverr)
    else $error("apb access not completed at once");
  chk_irq_sticky: assert property (irq_o && !wr |=> irq_o)
    else $error("interrupt dropped without firmware write");
  chk_irq_mask: assert property (
    wr && paddr == 12'h01C && pwdata[3:0] == 4'h0 |=> !irq_o)
    else $error("interrupt not masked");
  chk_release_clock: assert property (
    wr && paddr == 12'h000 && pwdata[4] |-> ##[1:2] !scl_oe_o)
    else $error("clock not released");
  chk_stretch_low: assert property (
    $rose(scl_oe_o) |-> !$past(scl_i))
    else $error("stretch began with clock high");
  chk_stretch_hold: assert property (
    scl_oe_o && !(wr && paddr == 12'h000) |=> scl_oe_o)
    else $error("stretch ended without release");
  chk_buf_clear: assert property (
    (rd && paddr == 12'h010) ##[1:4] (rd && paddr == 12'h00C)
    |-> !prdata[0])
    else $error("buffer read left full flag");
  chk_buf_full: assert property (
    (wr && paddr == 12'h010) ##[1:4] (rd && paddr == 12'h00C)
    |-> prdata[0])
    else $error("buffer load did not set full flag");
  chk_sda_scl_low: assert property (
    $changed(sda_oe_o) |-> !$past(scl_i))
    else $error("data line moved while clock high");
  cov_stretch: cover property ($rose(scl_oe_o));
  cov_ack_drive: cover property ($rose(sda_oe_o));
  cov_irq: cover property ($rose(irq_o));
endmodule
bind serial_port_i2c_slave_tx_hold sp_checker sp_checker_i (.*);

// [verification/i2c_master_model.sv]
`timescale 1ns/1ps
module i2c_master_model (
  // clock
  input wire clk_i,
  // bus wires
  input wire scl_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_o
);
  integer n;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task hold(input integer k);
    repeat (k) @(posedge clk_i);
  endtask
  task start;
    begin
      sda_o <= 1'b0;
      hold(8);
      scl_o <= 1'b0;
      hold(4);
    end
  endtask
  task stop;
    begin
      sda_o <= 1'b0;
      hold(4);
      scl_o <= 1'b1;
      hold(8);
      sda_o <= 1'b1;
      hold(8);
    end
  endtask
  // high phase counts only once a stretch is over
  task clk_bit(input b, output r);
    begin
      hold(4);
      sda_o <= b;
      hold(4);
      scl_o <= 1'b1;
      for (n = 0; scl_i !== 1'b1 && n < 4000; n = n + 1)
        @(posedge clk_i);
      hold(4);
      r = sda_i;
      hold(4);
      scl_o <= 1'b0;
    end
  endtask
  task byte_io(input [7:0] tx, input ack_i, output [7:0] rx, output ack_o);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        clk_bit(tx[i], r);
        rx[i] = r;
      end
      clk_bit(ack_i, ack_o);
    end
  endtask
endmodule

// [verification/serial_port_i2c_slave_tx_hold_tb_top.sv]
`timescale 1ns/1ps
module serial_port_i2c_slave_tx_hold_tb_top;
  reg ref_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg timer_two_i = 1'b0;
  reg [31:0] rd;
  reg [7:0] rx;
  reg [7:0] d;
  reg ak;
  integer miscompares = 0;
  integer checks = 0;
  integer i;
  wire [31:0] prdata;
  wire pready, pslverr, scl_o, scl_oe_o, sda_o, sda_oe_o;
  wire spi_sck_o, irq_o, m_scl, m_sda;
  // open-drain wires with pull-ups
  wire scl_w = m_scl & ~scl_oe_o;
  wire sda_w = m_sda & ~sda_oe_o;
  always #25 ref_clk_i = ~ref_clk_i;
  always begin
    repeat (5) @(posedge ref_clk_i);
    timer_two_i <= ~timer_two_i;
  end
  serial_port_i2c_slave_tx_hold serial_port_i2c_slave_tx_hold_i (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .timer_two_i(timer_two_i),
    .spi_sck_o(spi_sck_o), .irq_o(irq_o));
  i2c_master_model i2c_master_model_i (.clk_i(ref_clk_i), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] v);
    integer n;
    begin
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      @(posedge ref_clk_i);
      for (n = 0; pready !== 1'b1 && n < 100; n = n + 1)
        @(posedge ref_clk_i);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wait_irq;
    integer n;
    for (n = 0; irq_o !== 1'b1 && n < 3000; n = n + 1)
      @(posedge ref_clk_i);
  endtask
  task t_regs;
    begin
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h030, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h014, 32'h3F);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd[7:0], 8'h3F);
    end
  endtask
  task t_start;
    begin
      apb(1'b1, 12'h008, 32'h22);
      apb(1'b1, 12'h01C, 32'hF);
      apb(1'b1, 12'h000, 32'h36);
      i2c_master_model_i.start;
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd[3], 1'b1);
      chk(irq_o, 1'b1);
      apb(1'b1, 12'h01C, 32'h0);
      @(negedge ref_clk_i);
      chk(irq_o, 1'b0);
      apb(1'b1, 12'h01C, 32'hF);
      @(negedge ref_clk_i);
      chk(irq_o, 1'b1);
      apb(1'b1, 12'h020, 32'hF);
      @(negedge ref_clk_i);
      chk(irq_o, 1'b0);
    end
  endtask
  task t_addr;
    begin
      fork
        i2c_master_model_i.byte_io({7'h2A, 1'b1}, 1'b1, rx, ak);
        begin
          wait_irq;
          apb(1'b0, 12'h018, 32'h0);
          chk(rd[3:0], 4'h2);
          chk(scl_oe_o, 1'b1);
          apb(1'b0, 12'h00C, 32'h0);
          chk({rd[5], rd[2]}, 2'b01);
          apb(1'b0, 12'h008, 32'h0);
          chk(rd[7], 1'b1);
          apb(1'b0, 12'h010, 32'h0);
          chk(rd[7:0], {7'h2A, 1'b1});
          apb(1'b0, 12'h00C, 32'h0);
          chk(rd[0], 1'b0);
          apb(1'b1, 12'h020, 32'hF);
          apb(1'b1, 12'h004, 32'h0);
          apb(1'b1, 12'h000, 32'h36);
        end
      join
      chk(ak, 1'b0);
    end
  endtask
  task t_bytes;
    for (i = 0; i < 2; i = i + 1) begin
      d = i ? 8'h3C : 8'hA5;
      fork
        i2c_master_model_i.byte_io(8'hFF, i[0], rx, ak);
        begin
          wait_irq;
          apb(1'b0, 12'h018, 32'h0);
          chk(rd[3:0], 4'h4);
          chk(scl_oe_o, 1'b1);
          apb(1'b1, 12'h020, 32'hF);
          apb(1'b1, 12'h010, {24'h0, d});
          apb(1'b0, 12'h00C, 32'h0);
          chk(rd[0], 1'b1);
          apb(1'b1, 12'h000, 32'h36);
        end
      join
      chk(rx, d);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[6], i[0]);
    end
    chk({scl_oe_o, sda_oe_o}, 2'b00);
    i2c_master_model_i.stop;
  endtask
  task t_modes;
    time t0;
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 12'h000, 32'h20 + i);
      @(posedge spi_sck_o);
      @(posedge spi_sck_o);
      t0 = $time;
      @(posedge spi_sck_o);
      chk(($time - t0) / 50, i == 3 ? 20 : 4 << (2 * i));
    end
  endtask
  task final_report;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_start;
    t_addr;
    t_bytes;
    t_modes;
    final_report;
  end
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    final_report;
  end
endmodule
